//--- verilog/servo_pkg.sv
// constants and register map of the trajectory and pid filter
package servo_pkg;
  localparam int          DATA_W          = 32;
  localparam int          ADDR_W          = 8;
  localparam int          SAMPLE_CYCLES   = 2048;
  localparam logic [7:0]  DERIV_RST       = 8'h00;
  localparam logic [31:0] PARAM_RST       = 32'h0000_0000;
  localparam logic [15:0] COEF_RST        = 16'h0000;
  localparam logic [11:0] ZERO_OUT_8      = 12'h080;
  localparam logic [11:0] ZERO_OUT_12     = 12'h800;
  localparam int          INTEG_W         = 24;
  localparam int          INTEG_SHIFT     = 8;
  localparam int          FRAC_W          = 16;
  // register byte offsets
  localparam logic [7:0]  CONTROL_OFS     = 8'h00;
  localparam logic [7:0]  TARGET_OFS      = 8'h04;
  localparam logic [7:0]  VELOCITY_OFS    = 8'h08;
  localparam logic [7:0]  ACCEL_OFS       = 8'h0c;
  localparam logic [7:0]  PGAIN_OFS       = 8'h10;
  localparam logic [7:0]  IGAIN_OFS       = 8'h14;
  localparam logic [7:0]  DGAIN_OFS       = 8'h18;
  localparam logic [7:0]  ILIMIT_OFS      = 8'h1c;
  localparam logic [7:0]  DINTERVAL_OFS   = 8'h20;
  localparam logic [7:0]  DES_POS_OFS     = 8'h24;
  localparam logic [7:0]  ACT_POS_OFS     = 8'h28;
  localparam logic [7:0]  DES_VEL_OFS     = 8'h2c;
  localparam logic [7:0]  INTEG_OFS       = 8'h30;
  localparam logic [7:0]  MOTOR_OFS       = 8'h34;
  // control fields
  localparam int          CTRL_WIDE_BIT   = 0;
  localparam int          CTRL_RUN_BIT    = 1;
  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;
endpackage : servo_pkg

//--- verilog/servo_if.sv
// loop signals shared by trajectory, encoder and filter
`timescale 1ns/1ns
interface servo_if;
  logic               sample_tick;
  logic signed [31:0] desired_pos;
  logic        [31:0] desired_vel;
  logic signed [31:0] actual_pos;
  modport traj (input sample_tick, output desired_pos, output desired_vel);
  modport enc  (output actual_pos);
  modport core (output sample_tick, input desired_pos, input desired_vel,
                input actual_pos);
endinterface : servo_if

//--- verilog/quad_decoder.sv
// quadrature encoder counter, four counts per line
`timescale 1ns/1ns
module quad_decoder
  import servo_pkg::*;
(
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // encoder pins
  input  wire logic enc_a,
  input  wire logic enc_b,
  // position out
  servo_if.enc      loop
);
  logic [1:0]         a_sync_reg;
  logic [1:0]         b_sync_reg;
  logic               a_last_reg;
  logic               b_last_reg;
  logic signed [31:0] count_reg;

  // two-stage synchronisers, free-running: no false edge after reset
  always_ff @(posedge aclk) begin
    a_sync_reg <= {a_sync_reg[0], enc_a};
    b_sync_reg <= {b_sync_reg[0], enc_b};
    a_last_reg <= a_sync_reg[1];
    b_last_reg <= b_sync_reg[1];
  end

  // every edge of either phase counts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= 32'sh0;
    end else if ((a_sync_reg[1] != a_last_reg) ||
                 (b_sync_reg[1] != b_last_reg)) begin
      if (a_sync_reg[1] ^ b_last_reg) begin
        count_reg <= count_reg + 32'sh1;
      end else begin
        count_reg <= count_reg - 32'sh1;
      end
    end
  end

  assign loop.actual_pos = count_reg;
endmodule : quad_decoder

//--- verilog/trajectory_gen.sv
// profile generator: velocity ramp and fractional position advance
`timescale 1ns/1ns
module trajectory_gen
  import servo_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // parameters
  input  wire logic        run,
  input  wire logic [31:0] target_pos,
  input  wire logic [31:0] cmd_vel,
  input  wire logic [31:0] cmd_accel,
  // loop
  servo_if.traj            loop
);
  logic signed [31:0] pos_reg;
  logic        [15:0] frac_reg;
  logic        [31:0] vel_reg;
  logic        [31:0] vel_next;
  logic        [16:0] frac_sum;
  logic signed [32:0] step;
  logic signed [32:0] remain;
  logic               forward;

  // ramp toward commanded velocity, stop adding once there
  always_comb begin
    if (vel_reg < cmd_vel) begin
      vel_next = (cmd_vel - vel_reg > cmd_accel) ?
                 vel_reg + cmd_accel : cmd_vel;
    end else if (vel_reg > cmd_vel) begin
      vel_next = (vel_reg - cmd_vel > cmd_accel) ?
                 vel_reg - cmd_accel : cmd_vel;
    end else begin
      vel_next = vel_reg;
    end
  end

  // integer counts plus carry of the fraction
  assign frac_sum = {1'b0, frac_reg} + {1'b0, vel_reg[FRAC_W-1:0]};
  assign step     = $signed({17'h0, vel_reg[31:FRAC_W]}) +
                    $signed({32'h0, frac_sum[FRAC_W]});
  assign remain   = $signed({target_pos[31], target_pos}) -
                    $signed({pos_reg[31], pos_reg});
  assign forward  = !remain[32];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_reg  <= PARAM_RST;
      frac_reg <= 16'h0;
      vel_reg  <= PARAM_RST;
    end else if (loop.sample_tick && run) begin
      frac_reg <= frac_sum[FRAC_W-1:0];
      if ((forward ? remain : -remain) <= step) begin
        pos_reg <= target_pos;
        vel_reg <= PARAM_RST;
      end else begin
        pos_reg <= forward ? pos_reg + step[31:0] : pos_reg - step[31:0];
        vel_reg <= vel_next;
      end
    end
  end

  assign loop.desired_pos = pos_reg;
  assign loop.desired_vel = vel_reg;
endmodule : trajectory_gen

//--- verilog/trajectory_and_pid_filter.sv
// servo loop top: register slave, sample timing and pid filter
//
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module trajectory_and_pid_filter
  import servo_pkg::*;
#(
  parameter int SAMPLE_LEN = SAMPLE_CYCLES
)(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // encoder pins
  input  wire logic        enc_a,
  input  wire logic        enc_b,
  // motor drive
  output logic [11:0]      motor_out,
  output logic             sample_strobe
);
  servo_if loop ();

  logic        [1:0]  control_reg;
  logic        [31:0] target_reg;
  logic        [31:0] velocity_reg;
  logic        [31:0] accel_reg;
  logic        [15:0] pgain_reg;
  logic        [15:0] igain_reg;
  logic        [15:0] dgain_reg;
  logic        [15:0] ilimit_reg;
  logic        [7:0]  dinterval_reg;
  logic        [1:0]  bresp_reg;
  logic               bvalid_reg;
  logic        [31:0] rdata_reg;
  logic        [1:0]  rresp_reg;
  logic               rvalid_reg;
  logic        [11:0] sample_cnt_reg;
  logic        [7:0]  dcnt_reg;
  logic signed [23:0] integ_reg;
  logic signed [15:0] prev_err_reg;
  logic signed [15:0] dterm_reg;
  logic        [11:0] motor_reg;
  logic               wr_fire;
  logic               deriv_tick;
  logic        [31:0] rd_value;
  logic               rd_hit;
  logic               wr_hit;
  logic signed [32:0] err_full;
  logic signed [15:0] err;
  logic signed [23:0] integ_next;
  logic signed [15:0] integ_val;
  logic signed [15:0] pterm;
  logic signed [15:0] iprod;
  logic        [15:0] imag;
  logic signed [15:0] iterm;
  logic signed [15:0] dprod;
  logic signed [17:0] sum_full;
  logic signed [15:0] sum_sat;

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // write channel: address and data taken together
  assign wr_fire       = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  always_comb begin
    unique case (s_axi_awaddr)
      CONTROL_OFS, TARGET_OFS, VELOCITY_OFS, ACCEL_OFS, PGAIN_OFS,
      IGAIN_OFS, DGAIN_OFS, ILIMIT_OFS, DINTERVAL_OFS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // parameter registers, all cleared by reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_reg   <= 2'h0;
      target_reg    <= PARAM_RST;
      velocity_reg  <= PARAM_RST;
      accel_reg     <= PARAM_RST;
      pgain_reg     <= COEF_RST;
      igain_reg     <= COEF_RST;
      dgain_reg     <= COEF_RST;
      ilimit_reg    <= COEF_RST;
      dinterval_reg <= DERIV_RST;
    end else if (wr_fire) begin
      unique case (s_axi_awaddr)
        CONTROL_OFS:
          control_reg <= 2'(merge({30'h0, control_reg}, s_axi_wdata,
                                  s_axi_wstrb));
        TARGET_OFS:
          target_reg <= merge(target_reg, s_axi_wdata, s_axi_wstrb);
        VELOCITY_OFS:
          velocity_reg <= merge(velocity_reg, s_axi_wdata, s_axi_wstrb);
        ACCEL_OFS:
          accel_reg <= merge(accel_reg, s_axi_wdata, s_axi_wstrb);
        PGAIN_OFS:
          pgain_reg <= 16'(merge({16'h0, pgain_reg}, s_axi_wdata,
                                 s_axi_wstrb));
        IGAIN_OFS:
          igain_reg <= 16'(merge({16'h0, igain_reg}, s_axi_wdata,
                                 s_axi_wstrb));
        DGAIN_OFS:
          dgain_reg <= 16'(merge({16'h0, dgain_reg}, s_axi_wdata,
                                 s_axi_wstrb));
        ILIMIT_OFS:
          ilimit_reg <= 16'(merge({16'h0, ilimit_reg}, s_axi_wdata,
                                  s_axi_wstrb));
        DINTERVAL_OFS:
          dinterval_reg <= 8'(merge({24'h0, dinterval_reg}, s_axi_wdata,
                                    s_axi_wstrb));
        default: ;
      endcase
    end
  end

  // read mux
  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      CONTROL_OFS:   rd_value = {30'h0, control_reg};
      TARGET_OFS:    rd_value = target_reg;
      VELOCITY_OFS:  rd_value = velocity_reg;
      ACCEL_OFS:     rd_value = accel_reg;
      PGAIN_OFS:     rd_value = {16'h0, pgain_reg};
      IGAIN_OFS:     rd_value = {16'h0, igain_reg};
      DGAIN_OFS:     rd_value = {16'h0, dgain_reg};
      ILIMIT_OFS:    rd_value = {16'h0, ilimit_reg};
      DINTERVAL_OFS: rd_value = {24'h0, dinterval_reg};
      DES_POS_OFS:   rd_value = loop.desired_pos;
      ACT_POS_OFS:   rd_value = loop.actual_pos;
      DES_VEL_OFS:   rd_value = loop.desired_vel;
      INTEG_OFS:     rd_value = {{8{integ_reg[23]}}, integ_reg};
      MOTOR_OFS:     rd_value = {20'h0, motor_reg};
      default: begin
        rd_value = 32'h0;
        rd_hit   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0;
      rresp_reg  <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_value;
      rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // sample and derivative interval timing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_cnt_reg <= 12'h0;
    end else if (sample_cnt_reg == 12'(SAMPLE_LEN - 1)) begin
      sample_cnt_reg <= 12'h0;
    end else begin
      sample_cnt_reg <= sample_cnt_reg + 12'h1;
    end
  end

  assign loop.sample_tick = (sample_cnt_reg == 12'(SAMPLE_LEN - 1));
  assign sample_strobe    = loop.sample_tick;
  assign deriv_tick       = loop.sample_tick && (dcnt_reg == dinterval_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dcnt_reg <= DERIV_RST;
    end else if (deriv_tick) begin
      dcnt_reg <= 8'h0;
    end else if (loop.sample_tick) begin
      dcnt_reg <= dcnt_reg + 8'h1;
    end
  end

  // error formation and saturation
  assign err_full = $signed({loop.desired_pos[31], loop.desired_pos}) -
                    $signed({loop.actual_pos[31], loop.actual_pos});
  always_comb begin
    if (err_full > 33'sh7fff) begin
      err = 16'sh7fff;
    end else if (err_full < -33'sh8000) begin
      err = -16'sh8000;
    end else begin
      err = err_full[15:0];
    end
  end

  // proportional, integral and derivative arithmetic
  assign pterm      = 16'(pgain_reg * err);
  assign integ_next = integ_reg + 24'(err);
  assign integ_val  = integ_next[23:8];
  assign iprod      = 16'($signed(igain_reg) *
                          (integ_val >>> INTEG_SHIFT));
  assign imag       = iprod[15] ? 16'(-iprod) : iprod;
  assign iterm      = (imag > ilimit_reg) ?
                      (iprod[15] ? 16'(-ilimit_reg) : ilimit_reg) :
                      iprod;
  assign dprod      = 16'($signed(dgain_reg) *
                          16'(err - prev_err_reg));
  assign sum_full   = 18'(pterm) + 18'(iterm) + 18'(dterm_reg);
  assign sum_sat    = (sum_full > 18'sh7fff) ? 16'sh7fff :
                      (sum_full < -18'sh8000) ? -16'sh8000 :
                      sum_full[15:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      integ_reg <= 24'sh0;
    end else if (loop.sample_tick) begin
      integ_reg <= integ_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_err_reg <= 16'sh0;
      dterm_reg    <= 16'sh0;
    end else if (deriv_tick) begin
      prev_err_reg <= err;
      dterm_reg    <= dprod;
    end
  end

  // offset-binary output, top bits by mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      motor_reg <= ZERO_OUT_8;
    end else if (loop.sample_tick) begin
      if (control_reg[CTRL_WIDE_BIT]) begin
        motor_reg <= sum_sat[15:4] ^ ZERO_OUT_12;
      end else begin
        motor_reg <= {4'h0, sum_sat[15:8]} ^ ZERO_OUT_8;
      end
    end
  end

  assign motor_out = motor_reg;

  trajectory_gen u_traj (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .run       (control_reg[CTRL_RUN_BIT]),
    .target_pos(target_reg),
    .cmd_vel   (velocity_reg),
    .cmd_accel (accel_reg),
    .loop      (loop)
  );

  quad_decoder u_quad (
    .aclk   (aclk),
    .aresetn(aresetn),
    .enc_a  (enc_a),
    .enc_b  (enc_b),
    .loop   (loop)
  );
endmodule : trajectory_and_pid_filter

//--- testbench/servo_properties.sv
// concurrent checks on the servo top ports
`timescale 1ns/1ns
module servo_checks
  import servo_pkg::*;
#(
  parameter int SAMPLE_LEN = SAMPLE_CYCLES
)(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // write channels
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // read channels
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // loop outputs
  input wire logic [11:0] motor_out,
  input wire logic        sample_strobe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  int   gap_cnt;
  logic seen_tick;
  // cycles since the last sample strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_cnt   <= 0;
      seen_tick <= 1'b0;
    end else if (sample_strobe) begin
      gap_cnt   <= 0;
      seen_tick <= 1'b1;
    end else begin
      gap_cnt <= gap_cnt + 1;
    end
  end
  sequence s_write_taken;
    s_axi_awvalid && s_axi_wvalid && s_axi_awready;
  endsequence
  sequence s_resp_waiting;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  a_write_answer: assert property (s_write_taken |=> s_axi_bvalid)
    else $error("write response missing");
  a_bresp_stands: assert property (s_resp_waiting |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read data missing");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_arready_idle: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read address ready wrong");
  a_motor_reset_zero: assert property ($rose(aresetn) |->
    motor_out == ZERO_OUT_8)
    else $error("motor output not zero after reset");
  a_motor_on_sample: assert property ($changed(motor_out) |->
    $past(sample_strobe))
    else $error("motor output changed between samples");
  a_tick_period: assert property (sample_strobe && seen_tick |->
    gap_cnt == SAMPLE_LEN - 1)
    else $error("sample period wrong");
  a_tick_not_late: assert property (seen_tick |-> gap_cnt < SAMPLE_LEN)
    else $error("sample strobe late");
endmodule : servo_checks

//--- testbench/quad_encoder_model.sv
// quadrature encoder: one pin changes per step
`timescale 1ns/1ns
module quad_encoder_model (
  // clock
  input  wire logic aclk,
  // step requests
  input  wire logic fwd,
  input  wire logic rev,
  // encoder pins
  output logic      enc_a,
  output logic      enc_b
);
  logic [1:0] phase_reg = 2'h0;
  always @(posedge aclk) begin
    if (fwd) phase_reg <= phase_reg + 2'h1;
    else if (rev) phase_reg <= phase_reg - 2'h1;
  end
  // forward order 00, 10, 11, 01
  assign enc_a = phase_reg[1] ^ phase_reg[0];
  assign enc_b = phase_reg[1];
endmodule : quad_encoder_model

//--- testbench/trajectory_and_pid_filter_tb.sv
// self-checking bench for the trajectory and pid filter
`timescale 1ns/1ns
module trajectory_and_pid_filter_tb;
  import servo_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, enc_a, enc_b;
  logic        sample_strobe, fwd, rev;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, v, prod;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [11:0] motor_out;
  logic [15:0] g, k;
  int          num_errors = 0, n_compared = 0, cycles = 0;
  logic [7:0]  ofs [9] = '{CONTROL_OFS, TARGET_OFS, VELOCITY_OFS, ACCEL_OFS,
    PGAIN_OFS, IGAIN_OFS, DGAIN_OFS, ILIMIT_OFS, DINTERVAL_OFS};
  logic [31:0] msk [9] = '{32'h3, 32'hffffffff, 32'hffffffff, 32'hffffffff,
    32'hffff, 32'hffff, 32'hffff, 32'hffff, 32'hff};

  trajectory_and_pid_filter #(.SAMPLE_LEN(16)) uut (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .s_axi_awaddr (s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata  (s_axi_wdata),
    .s_axi_wstrb  (s_axi_wstrb),
    .s_axi_wvalid (s_axi_wvalid),
    .s_axi_wready (s_axi_wready),
    .s_axi_bresp  (s_axi_bresp),
    .s_axi_bvalid (s_axi_bvalid),
    .s_axi_bready (s_axi_bready),
    .s_axi_araddr (s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata  (s_axi_rdata),
    .s_axi_rresp  (s_axi_rresp),
    .s_axi_rvalid (s_axi_rvalid),
    .s_axi_rready (s_axi_rready),
    .enc_a        (enc_a),
    .enc_b        (enc_b),
    .motor_out    (motor_out),
    .sample_strobe(sample_strobe)
  );
  quad_encoder_model encoder (
    .aclk (aclk),
    .fwd  (fwd),
    .rev  (rev),
    .enc_a(enc_a),
    .enc_b(enc_b)
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors++;
      conclude();
    end
  end

  task automatic conclude();
    if (num_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task automatic check(input string what, input logic [31:0] seen, want);
    n_compared++;
    if (seen !== want) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  function automatic logic [31:0] code(input logic [15:0] s, input bit w);
    return w ? {20'h0, s[15:4] ^ 12'h800} : {24'h0, s[15:8] ^ 8'h80};
  endfunction : code
  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask : do_reset
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
      end
      if (s_axi_bvalid) begin
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        return;
      end
    end
  endtask : wr
  task automatic rdreg(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rd  = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        return;
      end
    end
  endtask : rdreg
  task automatic samples(input int n);
    repeat (n) begin
      @(negedge aclk);
      while (!sample_strobe) @(negedge aclk);
      @(posedge aclk);
    end
    @(negedge aclk);
  endtask : samples
  task automatic steps(input int n, input logic dir);
    repeat (n) begin
      @(posedge aclk);
      fwd <= dir;
      rev <= !dir;
      @(posedge aclk);
      fwd <= 1'b0;
      rev <= 1'b0;
      repeat (2) @(posedge aclk);
    end
    repeat (6) @(posedge aclk);
  endtask : steps

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, fwd, rev} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    void'($urandom(32'hca6d));
    do_reset();
    check("motor_out", {20'h0, motor_out}, 32'h80);
    for (int a = 0; a <= 52; a += 4) begin
      rdreg(8'(a));
      check("reset value", rd, a == 52 ? 32'h80 : 32'h0);
    end
    for (int i = 0; i < 9; i++) begin
      v = $urandom;
      wr(ofs[i], v);
      rdreg(ofs[i]);
      check("register", rd, v & msk[i]);
    end
    do_reset();
    wr(8'h3c, 32'h1);
    check("bresp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(DES_POS_OFS, 32'h1234);
    check("bresp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    rdreg(DES_POS_OFS);
    check("read only", rd, 32'h0);
    rdreg(8'h38);
    check("rresp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    check("rdata", rd, 32'h0);
    // proportional path, both output widths
    for (int m = 0; m < 2; m++) begin
      do_reset();
      k = 16'($urandom_range(40, 1));
      g = 16'($urandom);
      wr(CONTROL_OFS, 32'(m));
      wr(PGAIN_OFS, {16'h0, g});
      steps(k, 1'b0);
      rdreg(ACT_POS_OFS);
      check("actual", rd, -32'(k));
      samples(2);
      prod = 32'(g) * 32'(k);
      check("motor_out", {20'h0, motor_out}, code(prod[15:0], m));
    end
    // velocity ramp and fractional advance
    do_reset();
    v = {16'($urandom_range(8, 1)), 16'h8000};
    wr(VELOCITY_OFS, v);
    wr(ACCEL_OFS, 32'h0000_8000);
    wr(TARGET_OFS, 32'h0010_0000);
    wr(CONTROL_OFS, 32'h2);
    samples(20);
    rdreg(DES_VEL_OFS);
    check("velocity", rd, v);
    samples(1);
    rdreg(DES_POS_OFS);
    prod = rd;
    samples(2);
    rdreg(DES_POS_OFS);
    check("advance", rd - prod, {15'h0, v[31:16], 1'b1});
    // derivative term, every sample then every other sample
    do_reset();
    g = 16'($urandom);
    k = 16'($urandom_range(4, 1));
    prod = 32'(g) * 32'(k);
    wr(DGAIN_OFS, {16'h0, g});
    wr(VELOCITY_OFS, {k, 16'h0});
    wr(ACCEL_OFS, {k, 16'h0});
    wr(TARGET_OFS, 32'h0010_0000);
    wr(CONTROL_OFS, 32'h2);
    samples(4);
    check("motor_out", {20'h0, motor_out}, code(prod[15:0], 1'b0));
    wr(DINTERVAL_OFS, 32'h1);
    samples(8);
    check("motor_out", {20'h0, motor_out},
          code({prod[14:0], 1'b0}, 1'b0));
    // integral limit and output saturation
    do_reset();
    wr(IGAIN_OFS, 32'h100);
    wr(ILIMIT_OFS, 32'h200);
    wr(VELOCITY_OFS, 32'h4000_0000);
    wr(ACCEL_OFS, 32'h4000_0000);
    wr(TARGET_OFS, 32'h7fff_0000);
    wr(CONTROL_OFS, 32'h3);
    samples(16);
    check("motor_out", {20'h0, motor_out}, 32'h820);
    wr(PGAIN_OFS, 32'h1);
    samples(2);
    check("motor_out", {20'h0, motor_out}, 32'hfff);
    wr(CONTROL_OFS, 32'h2);
    samples(2);
    check("motor_out", {20'h0, motor_out}, 32'h0ff);
    conclude();
  end
endmodule : trajectory_and_pid_filter_tb

bind trajectory_and_pid_filter servo_checks #(.SAMPLE_LEN(SAMPLE_LEN))
  checks (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wvalid (s_axi_wvalid),
    .s_axi_bresp  (s_axi_bresp),
    .s_axi_bvalid (s_axi_bvalid),
    .s_axi_bready (s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata  (s_axi_rdata),
    .s_axi_rvalid (s_axi_rvalid),
    .s_axi_rready (s_axi_rready),
    .motor_out    (motor_out),
    .sample_strobe(sample_strobe)
  );
